// ==== inc/pmlsc_cfg.svh ====
`ifndef PMLSC_CFG_SVH
`define PMLSC_CFG_SVH
// ==================================================
// Clock and timing
`define PMLSC_CLK_PERIOD_NS  50
`define PMLSC_RST_MIN_NS     2000
`define PMLSC_INIT_TIME_MS   2000
// ==================================================
// Two-wire slave
`define PMLSC_DEV_ADDR       7'h50
`define PMLSC_ID_VALUE       8'h5A // Arbitrary value
// ==================================================
// Memory map byte offsets
`define PMLSC_OFS_ID         8'h00
`define PMLSC_OFS_STATUS     8'h02
`define PMLSC_OFS_FLAGS      8'h03
`define PMLSC_OFS_MASK       8'h04
`define PMLSC_OFS_CHAN_DIS   8'h56
`define PMLSC_OFS_POWER      8'h5D
// ==================================================
// Field positions and reset values
`define PMLSC_STATUS_NR_BIT  0
`define PMLSC_FLAG_DONE_BIT  4
`define PMLSC_PWR_OVR_BIT    0
`define PMLSC_PWR_LOW_BIT    1
`define PMLSC_MASK_RST       8'h00
`define PMLSC_CHAN_DIS_RST   8'h00
`define PMLSC_POWER_RST      8'h00
`endif

// ==== inc/pmlsc_pkg.sv ====
package pmlsc_pkg;
  // ==================================================
  // Two-wire slave states
  typedef enum logic [2:0] {
    PMLSC_IDLE = 3'b000,
    PMLSC_ADDR = 3'b001,
    PMLSC_ACK  = 3'b010,
    PMLSC_WR   = 3'b011,
    PMLSC_RD   = 3'b100,
    PMLSC_RACK = 3'b101
  } pmlsc_state_t;
  // ==================================================
  // Per-channel shutdown controls
  typedef struct packed {
    logic [3:0] rx_dis;
    logic [3:0] tx_dis;
  } pmlsc_lane_t;
  // ==================================================
  // Open-drain pin drive
  typedef struct packed {
    logic o;
    logic oe;
  } pmlsc_od_t;
endpackage

// ==== verification/pmlsc_bench.sv ====
`timescale 1ns/10ps
`include "pmlsc_cfg.svh"
module pmlsc_bench;
  localparam int RMIN = 4;
  logic                   i_ref_clk;
  logic                   i_rstn;
  logic                   sel_n;
  logic                   mrst_n;
  logic                   lp_sel;
  logic [3:0]             fault;
  logic                   scl;
  logic                   sda;
  logic                   pres_n;
  pmlsc_pkg::pmlsc_od_t   int_od;
  pmlsc_pkg::pmlsc_od_t   sda_od;
  pmlsc_pkg::pmlsc_lane_t lane;
  logic                   low_pwr;
  logic                   not_rdy;
  logic                   int_line;
  logic [7:0]             lfsr_q;
  logic [7:0]             rd_byte;
  logic [7:0]             exp_q[$];
  int                     err_total;
  int                     cmp_count;
  event                   rd_ev;
  assign int_line = int_od.oe ? int_od.o : 1'b1;
  pmlsc_top #(.RST_MIN_CYC(RMIN), .INIT_CYC(50)) dut_u (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_module_select_n(sel_n), .i_module_reset_n(mrst_n),
    .i_low_power_select(lp_sel), .o_module_present_n(pres_n),
    .o_interrupt_n(int_od), .i_scl(scl), .i_sda(sda), .o_sda(sda_od),
    .i_lane_fault(fault), .o_lane_ctrl(lane), .o_low_power(low_pwr),
    .o_data_not_ready(not_rdy));
  pmlsc_host host_u (
    .i_ref_clk(i_ref_clk), .i_dut_sda(sda_od), .o_scl(scl), .o_sda(sda));
  // ==================================================
  // Checking and closing
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  task automatic test_done();
    $display("compares=%0d errors=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  task automatic snd(input logic [7:0] d, input logic ae);
    logic [7:0] r;
    logic       a;
    host_u.xbyte(d, 1'b1, r, a);
    chk1(a, ae);
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    host_u.start();
    snd({`PMLSC_DEV_ADDR, 1'b0}, 1'b0);
    snd(o, 1'b0);
    snd(d, 1'b0);
    host_u.stop();
  endtask
  task automatic rd(input logic [7:0] o, input logic [7:0] e);
    logic a;
    host_u.start();
    snd({`PMLSC_DEV_ADDR, 1'b0}, 1'b0);
    snd(o, 1'b0);
    host_u.start();
    snd({`PMLSC_DEV_ADDR, 1'b1}, 1'b0);
    exp_q.push_back(e);
    host_u.xbyte(8'hFF, 1'b1, rd_byte, a);
    -> rd_ev;
    host_u.stop();
  endtask
  // Bounded: a module that never gets ready ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    while (not_rdy !== 1'b0 && n < 400) begin
      tick(1);
      n++;
    end
    if (n == 400) begin
      err_total++;
      test_done();
    end
    tick(3);
  endtask
  initial begin
    forever begin
      @(rd_ev);
      chk(rd_byte, exp_q.pop_front());
    end
  end
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  // ==================================================
  // Main sequence
  initial begin
    i_rstn = 1'b0;
    sel_n = 1'b1;
    mrst_n = 1'b1;
    lp_sel = 1'b0;
    fault = 4'h0;
    lfsr_q = 8'h1E;
    tick(16);
    i_rstn = 1'b1;
    sel_n = 1'b0;
    wait_rdy();
    chk1(int_line, 1'b0);
    chk1(pres_n, 1'b0);
    rd(`PMLSC_OFS_FLAGS, 8'h10);
    rd(`PMLSC_OFS_ID, `PMLSC_ID_VALUE);
    rd(`PMLSC_OFS_STATUS, 8'h00);
    chk1(int_line, 1'b1);
    for (int i = 0; i < 3; i++) begin
      lfsr_q = lfsr(lfsr_q);
      wr(`PMLSC_OFS_CHAN_DIS, lfsr_q);
      tick(3);
      chk(lane, lfsr_q);
      rd(`PMLSC_OFS_CHAN_DIS, lfsr_q);
    end
    sel_n = 1'b1;
    tick(8);
    host_u.start();
    snd({`PMLSC_DEV_ADDR, 1'b0}, 1'b1);
    host_u.stop();
    sel_n = 1'b0;
    tick(8);
    host_u.start();
    snd(8'hA4, 1'b1);
    host_u.stop();
    rd(`PMLSC_OFS_CHAN_DIS, lfsr_q);
    lp_sel = 1'b1;
    tick(8);
    chk1(low_pwr, 1'b1);
    lp_sel = 1'b0;
    tick(8);
    chk1(low_pwr, 1'b0);
    wr(`PMLSC_OFS_POWER, 8'h03);
    tick(3);
    chk1(low_pwr, 1'b1);
    fault = 4'h4;
    tick(1);
    fault = 4'h0;
    tick(3);
    chk1(int_line, 1'b0);
    rd(`PMLSC_OFS_FLAGS, 8'h04);
    mrst_n = 1'b0;
    tick(RMIN - 2);
    mrst_n = 1'b1;
    tick(12);
    chk(lane, lfsr_q);
    chk1(not_rdy, 1'b0);
    mrst_n = 1'b0;
    tick(RMIN + 8);
    chk(lane, 8'h00);
    chk1(low_pwr, 1'b0);
    chk1(not_rdy, 1'b1);
    mrst_n = 1'b1;
    wait_rdy();
    chk1(int_line, 1'b0);
    rd(`PMLSC_OFS_FLAGS, 8'h10);
    test_done();
  end
endmodule // pmlsc_bench

// ==== verification/pmlsc_host.sv ====
`timescale 1ns/10ps
module pmlsc_host (
  // Clock
  input  wire logic                 i_ref_clk,
  // Bus pins
  input  wire pmlsc_pkg::pmlsc_od_t i_dut_sda,
  output logic                      o_scl,
  output logic                      o_sda
);
  logic pull_q;
  // ==================================================
  // Pull-up wins unless someone pulls low
  assign o_sda = pull_q ? 1'b0 : (i_dut_sda.oe ? i_dut_sda.o : 1'b1);
  initial begin
    o_scl = 1'b1;
    pull_q = 1'b0;
  end
  // Six clocks a phase keeps well above the filter latency
  task automatic half();
    repeat (6) @(negedge i_ref_clk);
  endtask
  task automatic start();
    pull_q = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    pull_q = 1'b1;
    half();
    o_scl = 1'b0;
  endtask
  task automatic stop();
    pull_q = 1'b1;
    half();
    o_scl = 1'b1;
    half();
    pull_q = 1'b0;
    half();
  endtask
  // Data bits move two clocks after the clock falls; start and stop move data with the fall
  task automatic xbit(input logic b, output logic r);
    repeat (2) @(negedge i_ref_clk);
    pull_q = !b;
    half();
    o_scl = 1'b1;
    half();
    r = o_sda;
    o_scl = 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic a,
                       output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r[i]);
    end
    xbit(a, ack);
  endtask
endmodule // pmlsc_host

// ==== verification/pmlsc_top_sva.sv ====
`timescale 1ns/10ps
module pmlsc_top_chk #(
  parameter int RST_MIN_CYC = 4,
  parameter int INIT_CYC    = 50,
  parameter int LANES       = 4
) (
  // Clock and reset
  input wire logic                   i_ref_clk,
  input wire logic                   i_rstn,
  // Host pins
  input wire logic                   i_module_select_n,
  input wire logic                   i_module_reset_n,
  input wire logic                   i_low_power_select,
  input wire logic                   o_module_present_n,
  input wire pmlsc_pkg::pmlsc_od_t   o_interrupt_n,
  // Bus
  input wire logic                   i_scl,
  input wire logic                   i_sda,
  input wire pmlsc_pkg::pmlsc_od_t   o_sda,
  // Internals
  input wire logic [LANES-1:0]       i_lane_fault,
  input wire pmlsc_pkg::pmlsc_lane_t o_lane_ctrl,
  input wire logic                   o_low_power,
  input wire logic                   o_data_not_ready
);
  // ==================================================
  // Length of the latest low run on the reset pin
  logic [15:0] run_q;
  logic [15:0] run_d;
  logic        pin_q;
  assign run_d = i_module_reset_n ? run_q :
                 (pin_q ? 16'h0001 : run_q + 16'h0001);
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_q <= 16'h0000;
      pin_q <= 1'b1;
    end else begin
      run_q <= run_d;
      pin_q <= i_module_reset_n;
    end
  end
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);
  // ==================================================
  // Properties
  sequence s_desel;
    i_module_select_n [*6];
  endsequence
  sequence s_ready;
    $fell(o_data_not_ready);
  endsequence
  property p_present;
    o_module_present_n == 1'b0;
  endproperty
  property p_od;
    !o_interrupt_n.o && !o_sda.o;
  endproperty
  property p_desel;
    s_desel |-> !o_sda.oe;
  endproperty
  property p_qual;
    !i_module_reset_n && int'(run_q) >= RST_MIN_CYC + 6
      |-> o_data_not_ready && o_lane_ctrl == '0;
  endproperty
  property p_short;
    $rose(o_data_not_ready) |-> int'(run_q) >= RST_MIN_CYC - 1;
  endproperty
  property p_done;
    s_ready |-> ##2 o_interrupt_n.oe;
  endproperty
  property p_fault;
    i_lane_fault != '0 && !o_data_not_ready |-> ##[1:2] o_interrupt_n.oe;
  endproperty
  property p_lp_lo;
    (o_data_not_ready && !i_low_power_select) [*6] |=> !o_low_power;
  endproperty
  a_present: assert property (p_present)
    else $error("presence pin not grounded");
  a_od: assert property (p_od)
    else $error("open-drain output drives high");
  a_desel: assert property (p_desel)
    else $error("data pulled while deselected");
  a_qual: assert property (p_qual)
    else $error("long reset pulse left settings");
  a_short: assert property (p_short)
    else $error("short reset pulse accepted");
  a_done: assert property (p_done)
    else $error("no interrupt on reset completion");
  a_fault: assert property (p_fault)
    else $error("lane fault raised no interrupt");
  a_lp_lo: assert property (p_lp_lo)
    else $error("low power stuck with pin low");
endmodule // pmlsc_top_chk
bind pmlsc_top pmlsc_top_chk #(
  .RST_MIN_CYC(RST_MIN_CYC), .INIT_CYC(INIT_CYC), .LANES(LANES)
) chk_u (.*);

// ==== verilog/pmlsc_top.sv ====
`timescale 1ns/10ps
`include "pmlsc_cfg.svh"

module pmlsc_top #(
  parameter int RST_MIN_CYC =
    (`PMLSC_RST_MIN_NS + `PMLSC_CLK_PERIOD_NS - 1) / `PMLSC_CLK_PERIOD_NS,
  parameter int INIT_CYC =
    (`PMLSC_INIT_TIME_MS * 1000000) / `PMLSC_CLK_PERIOD_NS,
  parameter int LANES = 4
) (
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rstn,
  // Host control pins
  input  wire logic                  i_module_select_n,
  input  wire logic                  i_module_reset_n,
  input  wire logic                  i_low_power_select,
  output logic                       o_module_present_n,
  output pmlsc_pkg::pmlsc_od_t       o_interrupt_n,
  // Two-wire bus
  input  wire logic                  i_scl,
  input  wire logic                  i_sda,
  output pmlsc_pkg::pmlsc_od_t       o_sda,
  // Module internals
  input  wire logic [LANES-1:0]      i_lane_fault,
  output pmlsc_pkg::pmlsc_lane_t     o_lane_ctrl,
  output logic                       o_low_power,
  output logic                       o_data_not_ready
);

  // ==================================================
  // Pin synchronisers: a level changes once stages 2 and 3 agree
  logic [2:0] sel_s_q, rst_s_q, lp_s_q, scl_s_q, sda_s_q;
  logic       sel_q, rstp_q, lp_q, scl_q, sda_q, scl_p_q, sda_p_q;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sel_s_q <= 3'h7;
      rst_s_q <= 3'h7;
      lp_s_q  <= 3'h7;
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end else begin
      sel_s_q <= {sel_s_q[1:0], i_module_select_n};
      rst_s_q <= {rst_s_q[1:0], i_module_reset_n};
      lp_s_q  <= {lp_s_q[1:0], i_low_power_select};
      scl_s_q <= {scl_s_q[1:0], i_scl};
      sda_s_q <= {sda_s_q[1:0], i_sda};
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sel_q   <= 1'b1;
      rstp_q  <= 1'b1;
      lp_q    <= 1'b1;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      if (sel_s_q[1] == sel_s_q[2]) sel_q <= sel_s_q[2];
      if (rst_s_q[1] == rst_s_q[2]) rstp_q <= rst_s_q[2];
      if (lp_s_q[1] == lp_s_q[2]) lp_q <= lp_s_q[2];
      if (scl_s_q[1] == scl_s_q[2]) scl_q <= scl_s_q[2];
      if (sda_s_q[1] == sda_s_q[2]) sda_q <= sda_s_q[2];
      scl_p_q <= scl_q;
      sda_p_q <= sda_q;
    end
  end
  // ==================================================
  // Reset qualification
  logic [31:0] rst_cnt_q;
  wire         soft_rst = (rst_cnt_q == 32'(RST_MIN_CYC));
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_cnt_q <= 32'h0000_0000;
    end else if (rstp_q) begin
      rst_cnt_q <= 32'h0000_0000;
    end else if (!soft_rst) begin
      rst_cnt_q <= rst_cnt_q + 32'h0000_0001;
    end
  end
  // ==================================================
  // Initialisation timer and not-ready flag
  // Runs from power-up as well, so no host reset is needed
  logic [31:0] init_cnt_q;
  logic        nr_q;
  wire         init_done = nr_q && (init_cnt_q == 32'(INIT_CYC - 1));
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      init_cnt_q <= 32'h0000_0000;
      nr_q       <= 1'b1;
    end else if (soft_rst) begin
      init_cnt_q <= 32'h0000_0000;
      nr_q       <= 1'b1;
    end else if (init_done) begin
      nr_q <= 1'b0;
    end else if (nr_q) begin
      init_cnt_q <= init_cnt_q + 32'h0000_0001;
    end
  end
  // ==================================================
  // Two-wire bus events
  wire start_ev = scl_q && scl_p_q && sda_p_q && !sda_q;
  wire stop_ev  = scl_q && scl_p_q && !sda_p_q && sda_q;
  wire scl_rise = scl_q && !scl_p_q;
  wire scl_fall = !scl_q && scl_p_q;
  wire selected = !sel_q;
  pmlsc_pkg::pmlsc_state_t state_q;
  logic [7:0] shift_q, tx_q, ptr_q;
  logic [3:0] bit_q;
  logic       rw_q, first_q, nack_q, sda_oe_q;
  logic       wr_stb_q, rd_stb_q;
  logic [7:0] wr_addr_q, wr_data_q, rd_addr_q, rd_val_q;
  // ==================================================
  // Memory map
  logic [7:0]  flags_q, mask_q, chan_q, power_q;
  logic [7:0]  rd_data;
  wire  [7:0]  status_v =
    8'({7'h00, nr_q}) << `PMLSC_STATUS_NR_BIT;
  wire         hit_id     = (ptr_q == `PMLSC_OFS_ID);
  wire         hit_status = (ptr_q == `PMLSC_OFS_STATUS);
  wire         hit_flags  = (ptr_q == `PMLSC_OFS_FLAGS);
  wire         hit_mask   = (ptr_q == `PMLSC_OFS_MASK);
  wire         hit_chan   = (ptr_q == `PMLSC_OFS_CHAN_DIS);
  wire         hit_power  = (ptr_q == `PMLSC_OFS_POWER);
  // Unmapped offsets read as zero
  assign rd_data = hit_id     ? `PMLSC_ID_VALUE :
                   hit_status ? status_v :
                   hit_flags  ? flags_q :
                   hit_mask   ? mask_q :
                   hit_chan   ? chan_q :
                   hit_power  ? power_q : 8'h00;
  // ==================================================
  // Two-wire slave machine
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q   <= pmlsc_pkg::PMLSC_IDLE;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      ptr_q     <= 8'h00;
      bit_q     <= 4'h0;
      rw_q      <= 1'b0;
      first_q   <= 1'b0;
      nack_q    <= 1'b0;
      sda_oe_q  <= 1'b0;
      wr_stb_q  <= 1'b0;
      rd_stb_q  <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      rd_addr_q <= 8'h00;
      rd_val_q  <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      if (!selected || stop_ev || soft_rst) begin
        state_q  <= pmlsc_pkg::PMLSC_IDLE;
        sda_oe_q <= 1'b0;
      end else if (start_ev) begin
        state_q  <= pmlsc_pkg::PMLSC_ADDR;
        bit_q    <= 4'h0;
        sda_oe_q <= 1'b0;
      end else begin
        unique case (state_q)
          pmlsc_pkg::PMLSC_IDLE: sda_oe_q <= 1'b0;
          pmlsc_pkg::PMLSC_ADDR: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_q};
              bit_q   <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h8) begin
              if (shift_q[7:1] == `PMLSC_DEV_ADDR) begin
                rw_q     <= shift_q[0];
                first_q  <= 1'b1;
                sda_oe_q <= 1'b1;
                state_q  <= pmlsc_pkg::PMLSC_ACK;
              end else begin
                state_q <= pmlsc_pkg::PMLSC_IDLE;
              end
            end
          end
          pmlsc_pkg::PMLSC_ACK: begin
            if (scl_fall) begin
              bit_q <= 4'h0;
              if (rw_q) begin
                // Read: load byte, first bit out at once
                rd_val_q  <= rd_data;
                tx_q      <= {rd_data[6:0], 1'b0};
                sda_oe_q  <= !rd_data[7];
                rd_stb_q  <= 1'b1;
                rd_addr_q <= ptr_q;
                ptr_q     <= ptr_q + 8'h01;
                state_q   <= pmlsc_pkg::PMLSC_RD;
              end else begin
                sda_oe_q <= 1'b0;
                state_q  <= pmlsc_pkg::PMLSC_WR;
              end
            end
          end
          pmlsc_pkg::PMLSC_WR: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_q};
              bit_q   <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h8) begin
              if (first_q) begin
                ptr_q <= shift_q;
              end else begin
                wr_stb_q  <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= shift_q;
                ptr_q     <= ptr_q + 8'h01;
              end
              first_q  <= 1'b0;
              rw_q     <= 1'b0;
              sda_oe_q <= 1'b1;
              state_q  <= pmlsc_pkg::PMLSC_ACK;
            end
          end
          pmlsc_pkg::PMLSC_RD: begin
            if (scl_rise) begin
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall) begin
              if (bit_q == 4'h8) begin
                sda_oe_q <= 1'b0;
                state_q  <= pmlsc_pkg::PMLSC_RACK;
              end else begin
                sda_oe_q <= !tx_q[7];
                tx_q     <= {tx_q[6:0], 1'b0};
              end
            end
          end
          pmlsc_pkg::PMLSC_RACK: begin
            if (scl_rise) begin
              nack_q <= sda_q;
            end else if (scl_fall) begin
              bit_q <= 4'h0;
              if (nack_q) begin
                state_q <= pmlsc_pkg::PMLSC_IDLE;
              end else begin
                rd_val_q  <= rd_data;
                tx_q      <= {rd_data[6:0], 1'b0};
                sda_oe_q  <= !rd_data[7];
                rd_stb_q  <= 1'b1;
                rd_addr_q <= ptr_q;
                ptr_q     <= ptr_q + 8'h01;
                state_q   <= pmlsc_pkg::PMLSC_RD;
              end
            end
          end
          default: begin
            state_q  <= pmlsc_pkg::PMLSC_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==================================================
  // Writable settings, back to defaults on a qualified reset
  wire wr_mask  = wr_stb_q && (wr_addr_q == `PMLSC_OFS_MASK);
  wire wr_chan  = wr_stb_q && (wr_addr_q == `PMLSC_OFS_CHAN_DIS);
  wire wr_power = wr_stb_q && (wr_addr_q == `PMLSC_OFS_POWER);
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mask_q  <= `PMLSC_MASK_RST;
      chan_q  <= `PMLSC_CHAN_DIS_RST;
      power_q <= `PMLSC_POWER_RST;
    end else if (soft_rst) begin
      mask_q  <= `PMLSC_MASK_RST;
      chan_q  <= `PMLSC_CHAN_DIS_RST;
      power_q <= `PMLSC_POWER_RST;
    end else begin
      if (wr_mask) mask_q <= wr_data_q;
      if (wr_chan) chan_q <= wr_data_q;
      if (wr_power) power_q <= wr_data_q;
    end
  end

  // ==================================================
  // Sticky flags: a read clears only the bits it returned, so an event
  // landing on the load edge is kept; a new event wins
  wire [7:0] flag_set = 8'({3'h0, init_done, 4'(i_lane_fault)});
  wire       rd_flags = rd_stb_q && (rd_addr_q == `PMLSC_OFS_FLAGS);
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flags_q <= 8'h00;
    end else if (soft_rst) begin
      flags_q <= 8'h00;
    end else begin
      flags_q <= (rd_flags ? flags_q & ~rd_val_q : flags_q) | flag_set;
    end
  end

  // ==================================================
  // Outputs
  logic int_oe_q, low_power_q;
  pmlsc_pkg::pmlsc_lane_t lane_q;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      int_oe_q    <= 1'b0;
      low_power_q <= 1'b1;
      lane_q      <= '0;
    end else begin
      int_oe_q    <= |(flags_q & ~mask_q);
      // Host pin rules unless software overrides, keeps a cool slot safe
      low_power_q <= power_q[`PMLSC_PWR_OVR_BIT] ?
                     power_q[`PMLSC_PWR_LOW_BIT] : lp_q;
      lane_q      <= chan_q;
    end
  end

  // Open drain: only ever pulls low or releases
  assign o_interrupt_n.o   = 1'b0;
  assign o_interrupt_n.oe  = int_oe_q;
  assign o_sda.o           = 1'b0;
  assign o_sda.oe          = sda_oe_q;
  assign o_module_present_n = 1'b0;
  assign o_low_power       = low_power_q;
  assign o_lane_ctrl       = lane_q;
  assign o_data_not_ready  = nr_q;
endmodule // pmlsc_top
